// ===== fskp_defines.svh
`ifndef FSKP_DEFINES_SVH
`define FSKP_DEFINES_SVH

// reference clock and line rate
`define FSKP_REF_HZ 3579545
`define FSKP_BAUD 1200
`define FSKP_BIT_REF ((`FSKP_REF_HZ + `FSKP_BAUD / 2) / `FSKP_BAUD)
`define FSKP_HALF_BIT (`FSKP_BIT_REF / 2)
`define FSKP_PULSE_REF (`FSKP_BIT_REF / 4)
// mark/space split and in-band limits, as half periods in ref cycles
`define FSKP_SPLIT_HZ 1700
`define FSKP_BAND_LO_HZ 500
`define FSKP_BAND_HI_HZ 3000
`define FSKP_THRESH_REF (`FSKP_REF_HZ / (2 * `FSKP_SPLIT_HZ))
`define FSKP_MIN_HALF (`FSKP_REF_HZ / (2 * `FSKP_BAND_HI_HZ))
`define FSKP_MAX_HALF (`FSKP_REF_HZ / (2 * `FSKP_BAND_LO_HZ))
// host shift clock half period
`define FSKP_MCLK_NS 4
`define FSKP_HOST_HALF_NS 32
`define FSKP_HOST_HALF (`FSKP_HOST_HALF_NS / `FSKP_MCLK_NS)
// host register map
`define FSKP_ADR_CTRL 8'h00
`define FSKP_ADR_STAT 8'h04
`define FSKP_ADR_RXD 8'h08
`define FSKP_ADR_IRQ 8'h0c
`define FSKP_ADR_MASK 8'h10
`define FSKP_CTRL_MODE 0
`define FSKP_CTRL_SLEEP 1
`define FSKP_CTRL_DEMOD 2
`define FSKP_CTRL_RST 3'h0
`define FSKP_IRQ_WORD 0
`define FSKP_IRQ_EVENT 1
`define FSKP_IRQ_CARR 2
`endif

// ===== fskp_pkg.sv
`default_nettype none
package fskp_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fskp_rx_t;
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_WAIT} fskp_hst_t;
    typedef logic [11:0] fskp_cnt_t;
    typedef logic [7:0] fskp_word_t;
endpackage
`default_nettype wire

// ===== fskp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fskp_if;
    logic mode;
    logic sleep_request;
    logic demod_enable;
    logic sclk_dev_o;
    logic sclk_dev_oe;
    logic sclk_host_o;
    logic sclk_host_oe;
    logic serial_shift_clock;
    logic serial_data;
    logic word_ready_n;
    logic carrier_present_n;
    logic event_flag_out;
    logic tone_qualified;
    logic alert_oe;
    logic alert_n;
    // shared clock wire resolved from the two enables, low when undriven
    assign serial_shift_clock = sclk_dev_oe ? sclk_dev_o :
                                (sclk_host_oe ? sclk_host_o : 1'b0);
    // open-drain alert with pull-up
    assign alert_n = ~alert_oe;
    modport device (
        input mode, sleep_request, demod_enable, serial_shift_clock,
        output sclk_dev_o, sclk_dev_oe, serial_data, word_ready_n,
        output carrier_present_n, event_flag_out, tone_qualified, alert_oe
    );
    modport host (
        output mode, sleep_request, demod_enable, sclk_host_o, sclk_host_oe,
        input serial_shift_clock, serial_data, word_ready_n,
        input carrier_present_n, event_flag_out, tone_qualified, alert_n
    );
endinterface
`default_nettype wire

// ===== fskp_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "fskp_defines.svh"

module fskp_device
    import fskp_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic REF_CLOCK_IN,
    output logic REF_CLOCK_OUT,
    input wire logic FSK_LINE_IN,
    input wire logic EVENT_SENSE_IN,
    input wire logic HOLD_NODE_IN,
    output logic HOLD_NODE_OUT,
    output logic HOLD_NODE_OE,
    input wire logic TONE_IN,
    fskp_if.device LINK
);
    localparam fskp_cnt_t BIT_M1 = 12'(`FSKP_BIT_REF - 1);
    localparam fskp_cnt_t HALF_M1 = 12'(`FSKP_HALF_BIT - 1);
    localparam fskp_cnt_t PULSE_M1 = 12'(`FSKP_PULSE_REF - 1);
    localparam fskp_cnt_t THRESH = 12'(`FSKP_THRESH_REF);
    localparam fskp_cnt_t MIN_HALF = 12'(`FSKP_MIN_HALF);
    localparam fskp_cnt_t MAX_HALF = 12'(`FSKP_MAX_HALF);

    // two-stage synchronisers for every pin input
    logic [8:0] pin_raw;
    logic [8:0] pin_q1;
    logic [8:0] pin_q2;
    assign pin_raw = {LINK.mode, LINK.sleep_request, LINK.demod_enable,
                      LINK.serial_shift_clock, EVENT_SENSE_IN, HOLD_NODE_IN,
                      REF_CLOCK_IN, FSK_LINE_IN, TONE_IN};
    // hold node idles high behind its pull-up, so reset there to avoid a false event
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pin_q1 <= 9'h008;
            pin_q2 <= 9'h008;
        end else begin
            pin_q1 <= pin_raw;
            pin_q2 <= pin_q1;
        end
    end

    logic mode_s;
    logic sleep_s;
    logic demod_s;
    logic sclk_s;
    logic sense_s;
    logic node_s;
    logic ref_s;
    logic fsk_s;
    logic tone_s;
    logic run;
    assign mode_s = pin_q2[8];
    assign sleep_s = pin_q2[7];
    assign demod_s = pin_q2[6];
    assign sclk_s = pin_q2[5];
    assign sense_s = pin_q2[4];
    assign node_s = pin_q2[3];
    assign ref_s = pin_q2[2];
    assign fsk_s = pin_q2[1];
    assign tone_s = pin_q2[0];
    // receive path only while awake and enabled
    assign run = ~sleep_s & demod_s;

    // edge finders on synchronised reference and shift clock
    logic ref_d_q;
    logic sclk_d_q;
    logic ref_tick;
    logic sclk_rise;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ref_d_q <= 1'b0;
            sclk_d_q <= 1'b0;
            REF_CLOCK_OUT <= 1'b1;
        end else begin
            ref_d_q <= ref_s;
            sclk_d_q <= sclk_s;
            REF_CLOCK_OUT <= ~ref_s;
        end
    end
    assign ref_tick = ref_s & ~ref_d_q;
    assign sclk_rise = sclk_s & ~sclk_d_q;

    // event path: works in sleep too, node held low while sense high
    logic flag_q;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            HOLD_NODE_OE <= 1'b0;
            HOLD_NODE_OUT <= 1'b0;
            flag_q <= 1'b1;
        end else begin
            HOLD_NODE_OE <= sense_s;
            HOLD_NODE_OUT <= 1'b0;
            flag_q <= ~(sense_s | HOLD_NODE_OE | ~node_s);
        end
    end

    // discriminator: half period in ref cycles picks mark or space
    fskp_cnt_t half_q;
    fskp_cnt_t quiet_q;
    logic fsk_d_q;
    logic line_bit_q;
    logic carrier_n_q;
    always_ff @(posedge MCLK) begin
        if (SRST || sleep_s) begin
            half_q <= 12'h000;
            quiet_q <= MAX_HALF;
            fsk_d_q <= 1'b0;
            line_bit_q <= 1'b1;
            carrier_n_q <= 1'b1;
        end else begin
            fsk_d_q <= fsk_s;
            if (fsk_s != fsk_d_q) begin
                half_q <= 12'h000;
                if (half_q >= MIN_HALF && half_q <= MAX_HALF) begin
                    line_bit_q <= (half_q >= THRESH);
                    quiet_q <= 12'h000;
                end
            end else if (ref_tick) begin
                if (half_q != 12'hfff) begin
                    half_q <= half_q + 12'h001;
                end
                if (quiet_q != MAX_HALF) begin
                    quiet_q <= quiet_q + 12'h001;
                end
            end
            carrier_n_q <= (quiet_q == MAX_HALF);
        end
    end

    // character framer at the bit rate, lsb first
    fskp_rx_t rx_q;
    fskp_cnt_t tmr_q;
    logic [2:0] idx_q;
    fskp_word_t shreg_q;
    logic bit_ev;
    logic word_ev;
    always_ff @(posedge MCLK) begin
        if (SRST || !run) begin
            rx_q <= RX_IDLE;
            tmr_q <= 12'h000;
            idx_q <= 3'h0;
            shreg_q <= 8'h00;
            bit_ev <= 1'b0;
            word_ev <= 1'b0;
        end else begin
            bit_ev <= 1'b0;
            word_ev <= 1'b0;
            case (rx_q)
                RX_IDLE: begin
                    tmr_q <= 12'h000;
                    if (!line_bit_q) begin
                        rx_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (ref_tick) begin
                        tmr_q <= tmr_q + 12'h001;
                        if (tmr_q == HALF_M1) begin
                            tmr_q <= 12'h000;
                            idx_q <= 3'h0;
                            rx_q <= line_bit_q ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (ref_tick) begin
                        tmr_q <= tmr_q + 12'h001;
                        if (tmr_q == BIT_M1) begin
                            tmr_q <= 12'h000;
                            shreg_q <= {line_bit_q, shreg_q[7:1]};
                            bit_ev <= 1'b1;
                            idx_q <= idx_q + 3'h1;
                            if (idx_q == 3'h7) begin
                                rx_q <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (ref_tick) begin
                        tmr_q <= tmr_q + 12'h001;
                        if (tmr_q == BIT_M1) begin
                            word_ev <= line_bit_q;
                            rx_q <= RX_IDLE;
                        end
                    end
                end
                default: rx_q <= RX_IDLE;
            endcase
        end
    end

    // serial port: pushed clock in mode 0, host-pulled word in mode 1
    logic data_q;
    logic sclk_o_q;
    logic sclk_oe_q;
    logic ready_n_q;
    logic last_q;
    logic pend_q;
    fskp_cnt_t ptmr_q;
    fskp_cnt_t rtmr_q;
    fskp_word_t out_q;
    logic [2:0] ocnt_q;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            data_q <= 1'b1;
            sclk_o_q <= 1'b0;
            sclk_oe_q <= 1'b1;
            ready_n_q <= 1'b1;
            last_q <= 1'b0;
            pend_q <= 1'b0;
            ptmr_q <= 12'h000;
            rtmr_q <= 12'h000;
            out_q <= 8'h00;
            ocnt_q <= 3'h0;
        end else begin
            sclk_oe_q <= ~mode_s;
            if (!run) begin
                sclk_o_q <= 1'b0;
                ready_n_q <= 1'b1;
                pend_q <= 1'b0;
                last_q <= 1'b0;
            end else if (!mode_s) begin
                data_q <= line_bit_q;
                pend_q <= 1'b0;
                if (bit_ev) begin
                    sclk_o_q <= 1'b1;
                    ptmr_q <= 12'h000;
                    last_q <= (idx_q == 3'h0);
                end else if (sclk_o_q && ref_tick) begin
                    ptmr_q <= ptmr_q + 12'h001;
                    if (ptmr_q == PULSE_M1) begin
                        sclk_o_q <= 1'b0;
                        if (last_q) begin
                            ready_n_q <= 1'b0;
                            rtmr_q <= 12'h000;
                        end
                    end
                end
                if (!ready_n_q && ref_tick) begin
                    rtmr_q <= rtmr_q + 12'h001;
                    if (rtmr_q == HALF_M1) begin
                        ready_n_q <= 1'b1;
                    end
                end
            end else begin
                sclk_o_q <= 1'b0;
                if (word_ev) begin
                    out_q <= shreg_q;
                    ocnt_q <= 3'h0;
                    pend_q <= 1'b1;
                    ready_n_q <= 1'b0;
                end else if (pend_q && sclk_rise) begin
                    data_q <= out_q[0];
                    out_q <= {1'b0, out_q[7:1]};
                    ocnt_q <= ocnt_q + 3'h1;
                    if (ocnt_q == 3'h7) begin
                        pend_q <= 1'b0;
                        ready_n_q <= 1'b1;
                    end
                end else if (!pend_q) begin
                    ready_n_q <= 1'b1;
                end
            end
        end
    end

    // alert output and mirrored status pins
    logic alert_q;
    logic tone_q;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            alert_q <= 1'b0;
            tone_q <= 1'b0;
        end else begin
            alert_q <= ~flag_q | ~ready_n_q | tone_q;
            tone_q <= tone_s;
        end
    end

    assign LINK.sclk_dev_o = sclk_o_q;
    assign LINK.sclk_dev_oe = sclk_oe_q;
    assign LINK.serial_data = data_q;
    assign LINK.word_ready_n = ready_n_q;
    assign LINK.carrier_present_n = carrier_n_q;
    assign LINK.event_flag_out = flag_q;
    assign LINK.tone_qualified = tone_q;
    assign LINK.alert_oe = alert_q;
endmodule
`default_nettype wire

// ===== fskp_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "fskp_defines.svh"

module fskp_host
    import fskp_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ,
    fskp_if.host LINK
);
    localparam logic [3:0] HALF_M1 = 4'(`FSKP_HOST_HALF - 1);

    // synchronisers: clock, data, ready, carrier, flag, tone, alert
    logic [6:0] pin_raw;
    logic [6:0] pin_q1;
    logic [6:0] pin_q2;
    assign pin_raw = {LINK.serial_shift_clock, LINK.serial_data,
                      LINK.word_ready_n, LINK.carrier_present_n,
                      LINK.event_flag_out, LINK.tone_qualified, LINK.alert_n};
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pin_q1 <= 7'h3f;
            pin_q2 <= 7'h3f;
        end else begin
            pin_q1 <= pin_raw;
            pin_q2 <= pin_q1;
        end
    end
    logic [6:0] pin_d_q;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pin_d_q <= 7'h3f;
        end else begin
            pin_d_q <= pin_q2;
        end
    end

    // wishbone slave, ack one cycle after the strobe
    logic [2:0] ctrl_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    fskp_word_t rxd_q;
    logic take;
    logic wr_lo;
    assign take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_lo = take & WB_WE_I & WB_SEL_I[0];
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
            ctrl_q <= `FSKP_CTRL_RST;
            mask_q <= 3'h0;
        end else begin
            WB_ACK_O <= take;
            WB_DAT_O <= 32'h0000_0000;
            if (take && !WB_WE_I) begin
                if (WB_ADR_I == `FSKP_ADR_CTRL) begin
                    WB_DAT_O <= {29'h0, ctrl_q};
                end else if (WB_ADR_I == `FSKP_ADR_STAT) begin
                    WB_DAT_O <= {28'h0, ~pin_q2[0], pin_q2[1],
                                 ~pin_q2[2], ~pin_q2[3]};
                end else if (WB_ADR_I == `FSKP_ADR_RXD) begin
                    WB_DAT_O <= {24'h0, rxd_q};
                end else if (WB_ADR_I == `FSKP_ADR_IRQ) begin
                    WB_DAT_O <= {29'h0, stat_q};
                end else if (WB_ADR_I == `FSKP_ADR_MASK) begin
                    WB_DAT_O <= {29'h0, mask_q};
                end
            end
            if (wr_lo && WB_ADR_I == `FSKP_ADR_CTRL) begin
                ctrl_q <= WB_DAT_I[2:0];
            end else if (wr_lo && WB_ADR_I == `FSKP_ADR_MASK) begin
                mask_q <= WB_DAT_I[2:0];
            end
        end
    end

    // word receiver: follows device clock in mode 0, drives it in mode 1
    fskp_hst_t st_q;
    logic [3:0] div_q;
    logic [3:0] bcnt_q;
    fskp_word_t sh_q;
    logic sclk_q;
    logic word_ev;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st_q <= H_IDLE;
            div_q <= 4'h0;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            sclk_q <= 1'b0;
            rxd_q <= 8'h00;
            word_ev <= 1'b0;
        end else begin
            word_ev <= 1'b0;
            if (!ctrl_q[`FSKP_CTRL_MODE]) begin
                st_q <= H_IDLE;
                sclk_q <= 1'b0;
                if (pin_q2[6] && !pin_d_q[6]) begin
                    sh_q <= {pin_q2[5], sh_q[7:1]};
                end
                if (!pin_q2[4] && pin_d_q[4]) begin
                    rxd_q <= sh_q;
                    word_ev <= 1'b1;
                end
            end else begin
                case (st_q)
                    H_IDLE: begin
                        div_q <= 4'h0;
                        bcnt_q <= 4'h0;
                        if (!pin_q2[4]) begin
                            st_q <= H_LOW;
                        end
                    end
                    H_LOW: begin
                        div_q <= div_q + 4'h1;
                        if (div_q == HALF_M1) begin
                            div_q <= 4'h0;
                            sclk_q <= 1'b1;
                            st_q <= H_HIGH;
                        end
                    end
                    H_HIGH: begin
                        div_q <= div_q + 4'h1;
                        if (div_q == HALF_M1) begin
                            div_q <= 4'h0;
                            sclk_q <= 1'b0;
                            sh_q <= {pin_q2[5], sh_q[7:1]};
                            bcnt_q <= bcnt_q + 4'h1;
                            st_q <= (bcnt_q == 4'h7) ? H_WAIT : H_LOW;
                        end
                    end
                    H_WAIT: begin
                        if (bcnt_q == 4'h8) begin
                            rxd_q <= sh_q;
                            word_ev <= 1'b1;
                            bcnt_q <= 4'h0;
                        end
                        if (pin_q2[4]) begin
                            st_q <= H_IDLE;
                        end
                    end
                    default: st_q <= H_IDLE;
                endcase
            end
        end
    end

    // sticky events, write one to clear, set wins
    logic [2:0] set_v;
    logic [2:0] clr_v;
    assign set_v = {~pin_q2[3] & pin_d_q[3], ~pin_q2[2] & pin_d_q[2], word_ev};
    assign clr_v = (wr_lo && WB_ADR_I == `FSKP_ADR_IRQ) ? WB_DAT_I[2:0] : 3'h0;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            stat_q <= 3'h0;
            IRQ <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~clr_v) | set_v;
            IRQ <= |(stat_q & mask_q);
        end
    end

    assign LINK.mode = ctrl_q[`FSKP_CTRL_MODE];
    assign LINK.sleep_request = ctrl_q[`FSKP_CTRL_SLEEP];
    assign LINK.demod_enable = ctrl_q[`FSKP_CTRL_DEMOD];
    assign LINK.sclk_host_o = sclk_q;
    assign LINK.sclk_host_oe = ctrl_q[`FSKP_CTRL_MODE];
endmodule
`default_nettype wire

// ===== fskp_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fskp_link_properties (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic mode,
    input wire logic sleep_request,
    input wire logic demod_enable,
    input wire logic sclk_dev_o,
    input wire logic sclk_dev_oe,
    input wire logic sclk_host_oe,
    input wire logic serial_shift_clock,
    input wire logic serial_data,
    input wire logic word_ready_n,
    input wire logic carrier_present_n,
    input wire logic event_flag_out,
    input wire logic tone_qualified,
    input wire logic alert_oe
);
    logic clk_q, rdy_q, cause;
    logic [3:0] rises_q;
    logic [5:0] since_q;
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    // any source that holds the alert
    assign cause = !event_flag_out || !word_ready_n || tone_qualified;
    // previous clock and ready levels
    always_ff @(posedge MCLK) begin
        clk_q <= serial_shift_clock;
        rdy_q <= word_ready_n;
    end
    // shift clock rises since ready fell
    always_ff @(posedge MCLK) begin
        if (SRST || (rdy_q && !word_ready_n)) begin
            rises_q <= 4'h0;
        end else if (!clk_q && serial_shift_clock && rises_q != 4'hf) begin
            rises_q <= rises_q + 4'h1;
        end
    end
    // cycles since the last rise
    always_ff @(posedge MCLK) begin
        if (SRST || (!clk_q && serial_shift_clock)) begin
            since_q <= 6'h0;
        end else if (since_q != 6'h3f) begin
            since_q <= since_q + 6'h1;
        end
    end
    property p_dev_clock;
        $past(mode, 4) == mode && $past(mode, 2) == mode |-> sclk_dev_oe == !mode;
    endproperty
    a_dev_clock: assert property (p_dev_clock) else $error("clock direction wrong");
    property p_host_clock;
        sclk_host_oe && $past(sclk_host_oe, 4) |-> !sclk_dev_oe;
    endproperty
    a_host_clock: assert property (p_host_clock) else $error("both ends drive the clock");
    property p_ready_off;
        !demod_enable && !$past(demod_enable, 6) |-> word_ready_n;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready with demod off");
    property p_sleep;
        sleep_request && $past(sleep_request, 6) |-> word_ready_n && carrier_present_n;
    endproperty
    a_sleep: assert property (p_sleep) else $error("activity while asleep");
    property p_no_clock;
        !demod_enable && !mode && !$past(demod_enable, 6) |-> !$rose(sclk_dev_o);
    endproperty
    a_no_clock: assert property (p_no_clock) else $error("clock with demod off");
    property p_alert_on;
        cause [*3] |-> alert_oe;
    endproperty
    a_alert_on: assert property (p_alert_on) else $error("alert missing");
    property p_alert_off;
        !cause [*3] |-> !alert_oe;
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("alert stuck");
    property p_m0_eight;
        rdy_q && !word_ready_n && !mode |-> rises_q == 4'h8;
    endproperty
    a_m0_eight: assert property (p_m0_eight) else $error("pulse count in mode 0");
    property p_m1_eight;
        !rdy_q && word_ready_n && mode |-> rises_q == 4'h8;
    endproperty
    a_m1_eight: assert property (p_m1_eight) else $error("pulse count in mode 1");
    property p_shift_rise;
        mode && $past(mode, 8) && $changed(serial_data) |-> since_q <= 6'h5;
    endproperty
    a_shift_rise: assert property (p_shift_rise) else $error("data moved off edge");
    c_m0_word: cover property (rdy_q && !word_ready_n && !mode);
    c_m1_word: cover property (!rdy_q && word_ready_n && mode);
    c_alert: cover property ($rose(alert_oe));
endmodule
`default_nettype wire

// ===== test_fsk_serial_data_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_fsk_serial_data_port
    import fskp_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, refc = 1'b0, fsk = 1'b0, node = 1'b1, sense = 1'b0;
    logic tone = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, clk_q = 1'b0;
    logic [7:0] adr = 8'h00, shift = 8'h00;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, irq, ref_out, node_out, node_oe;
    int half = 20000, ph = 0, rc = 0, miscompares = 0, total_checks = 0;
    fskp_if i_fskp_if ();
    fskp_device i_fskp_device (.MCLK(mclk), .SRST(srst), .REF_CLOCK_IN(refc),
        .REF_CLOCK_OUT(ref_out), .FSK_LINE_IN(fsk), .EVENT_SENSE_IN(sense), .HOLD_NODE_IN(node),
        .HOLD_NODE_OUT(node_out), .HOLD_NODE_OE(node_oe), .TONE_IN(tone), .LINK(i_fskp_if.device));
    fskp_host i_fskp_host (.MCLK(mclk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ(irq), .LINK(i_fskp_if.host));
    fskp_link_properties i_fskp_link_properties (.MCLK(mclk), .SRST(srst),
        .mode(i_fskp_if.mode), .sleep_request(i_fskp_if.sleep_request),
        .demod_enable(i_fskp_if.demod_enable), .sclk_dev_o(i_fskp_if.sclk_dev_o),
        .sclk_dev_oe(i_fskp_if.sclk_dev_oe), .sclk_host_oe(i_fskp_if.sclk_host_oe),
        .serial_shift_clock(i_fskp_if.serial_shift_clock), .serial_data(i_fskp_if.serial_data),
        .word_ready_n(i_fskp_if.word_ready_n), .carrier_present_n(i_fskp_if.carrier_present_n),
        .event_flag_out(i_fskp_if.event_flag_out), .tone_qualified(i_fskp_if.tone_qualified),
        .alert_oe(i_fskp_if.alert_oe));
    // clock at 4 ns
    initial begin
        forever #2 mclk = ~mclk;
    end
    // reference at half clock rate, line tone, rc node, shift monitor
    always @(posedge mclk) begin
        refc <= ~refc;
        ph <= (ph >= half - 1) ? 0 : ph + 1;
        if (ph >= half - 1) fsk <= ~fsk;
        rc <= node_oe ? 0 : (rc < 50 ? rc + 1 : rc);
        node <= !node_oe && rc >= 50;
        clk_q <= i_fskp_if.serial_shift_clock;
        // mode 0 bits are taken on the rise, mode 1 bits on the fall after the shift
        if (clk_q != i_fskp_if.serial_shift_clock && clk_q == i_fskp_if.mode) begin
            shift <= {i_fskp_if.serial_data, shift[7:1]};
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // classic wishbone single cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(q, e, nm);
    endtask
    // start, eight data lsb first, stop; a tick is two clocks
    task automatic send(input fskp_word_t w, input int mk, input int sp);
        logic [9:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < 10; i++) begin
            half <= 2 * (f[i] ? mk : sp);
            wt(5966);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        wt(130000);
        miscompares++;
        report_and_stop;
    end
    // test sequence
    initial begin
        wt(12);
        srst <= 1'b0;
        wt(1);
        rd(8'h00, 32'h0, "ctrl reset");
        wb(1'b1, 8'h10, 32'h7);
        rd(8'h10, 32'h7, "mask");
        wb(1'b1, 8'h14, 32'hff);
        rd(8'h14, 32'h0, "unmapped");
        sel <= 4'h0;
        wb(1'b1, 8'h00, 32'h7);
        sel <= 4'h1;
        rd(8'h00, 32'h0, "sel zero");
        $display("test registers done");
        wb(1'b1, 8'h00, 32'h2);
        sense <= 1'b1;
        wt(20);
        chk(i_fskp_if.event_flag_out, 32'h0, "event flag");
        chk(i_fskp_if.alert_n, 32'h0, "alert event");
        chk(irq, 32'h1, "irq event");
        rd(8'h04, 32'ha, "stat event");
        sense <= 1'b0;
        wt(30);
        chk(i_fskp_if.event_flag_out, 32'h0, "flag held");
        wt(60);
        chk(i_fskp_if.event_flag_out, 32'h1, "flag back");
        rd(8'h0c, 32'h2, "irq status");
        wb(1'b1, 8'h0c, 32'h2);
        rd(8'h0c, 32'h0, "irq cleared");
        chk(irq, 32'h0, "irq low");
        wb(1'b1, 8'h00, 32'h0);
        tone <= 1'b1;
        wt(10);
        chk(i_fskp_if.alert_n, 32'h0, "alert tone");
        rd(8'h04, 32'hc, "stat tone");
        tone <= 1'b0;
        wt(10);
        chk(i_fskp_if.alert_n, 32'h1, "alert idle");
        $display("test events done");
        wb(1'b1, 8'h00, 32'h4);
        send(8'ha5, 1491, 813);
        chk(shift, 32'ha5, "mode 0 wire");
        chk(i_fskp_if.sclk_dev_oe, 32'h1, "dev clock oe");
        chk(i_fskp_if.carrier_present_n, 32'h0, "carrier");
        rd(8'h08, 32'ha5, "mode 0 word");
        rd(8'h0c, 32'h5, "mode 0 irq");
        wb(1'b1, 8'h0c, 32'h7);
        $display("test mode 0 done");
        wb(1'b1, 8'h00, 32'h5);
        wt(10);
        chk(i_fskp_if.sclk_dev_oe, 32'h0, "dev clock off");
        chk(ref_out, refc, "ref out");
        send(8'h3c, 1377, 852);
        chk(shift, 32'h3c, "mode 1 wire");
        rd(8'h08, 32'h3c, "mode 1 word");
        rd(8'h0c, 32'h1, "mode 1 irq");
        chk(irq, 32'h1, "irq word");
        wb(1'b1, 8'h00, 32'h1);
        wt(20);
        chk(i_fskp_if.word_ready_n, 32'h1, "ready off");
        $display("test mode 1 done");
        report_and_stop;
    end
endmodule
`default_nettype wire
